// >>> mdx_regs.svh
// Opcode patterns, field positions and clock counts of the data-move decoder.
// Included by the decoder; holds definitions only.
`ifndef MDX_REGS_SVH
`define MDX_REGS_SVH

// Opcode patterns; short forms compare the upper seven bits only
`define MDX_OP_ACC_STORE_HI 7'h51
`define MDX_OP_SEG_LOAD 8'h8E
`define MDX_OP_SEG_STORE 8'h8C
`define MDX_OP_ESCAPE 8'h0F
`define MDX_OP_CTRL_WRITE 8'h22
`define MDX_OP_ZERO_EXT_HI 7'h5B
`define MDX_OP_SIGN_EXT_HI 7'h5F

// Modrm field positions
`define MDX_MOD_HI 7
`define MDX_MOD_LO 6
`define MDX_REG_HI 5
`define MDX_REG_LO 3
`define MDX_MOD_REGISTER 2'h3
`define MDX_SEG_LAST 3'h5

// Control register numbers
`define MDX_CTRL0 3'h0
`define MDX_CTRL2 3'h2
`define MDX_CTRL3 3'h3
`define MDX_CTRL4 3'h4

// Clock counts
`define MDX_CLK_ONE 5'h01
`define MDX_CLK_SEG_LOAD_PROT 5'h06
`define MDX_CLK_CTRL0_REAL 5'h14
`define MDX_CLK_CTRL0_PROT 5'h12
`define MDX_CLK_CTRL2 5'h05
`define MDX_CLK_CTRL3_REAL 5'h05
`define MDX_CLK_CTRL3_PROT 5'h06
`define MDX_CLK_CTRL4_REAL 5'h05
`define MDX_CLK_CTRL4_PROT 5'h06

`endif

// >>> mdx_pkg.sv
// Types shared by the data-move decoder and its testbench.
// No dependencies.
package mdx_pkg;

	typedef logic [4:0] mdx_count_t;

	typedef enum logic [2:0] {
		MDX_UNSUPPORTED,
		MDX_ACC_STORE,
		MDX_SEG_LOAD,
		MDX_SEG_STORE,
		MDX_CTRL_WRITE,
		MDX_SIGN_EXTEND,
		MDX_ZERO_EXTEND
	} mdx_kind_e;

	typedef struct packed {
		logic [7:0] op0;
		logic [7:0] op1;
		logic [7:0] modrm;
	} mdx_fetch_s;

	typedef struct packed {
		mdx_kind_e kind;
		logic [2:0] segment_register_field;
		logic [2:0] ctrl_index;
		logic wide;
		logic flags_write;
		mdx_count_t clocks;
		logic [31:0] ext_result;
	} mdx_issue_s;

endpackage : mdx_pkg

// >>> mdx_extend.sv
// Sign or zero extension of an 8- or 16-bit source to 32 bits.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module mdx_extend
	import mdx_pkg::*;
(
	// Source
	input wire logic [15:0] src,
	input wire logic wide,
	input wire logic sign,
	// Result
	output logic [31:0] result
);

	always_comb
	begin
		if (wide)
		begin
			result = {{16{sign & src[15]}}, src};
		end
		else
		begin
			result = {{24{sign & src[7]}}, src[7:0]};
		end
	end

endmodule : mdx_extend

// >>> mdx_decode.sv
// Decode and issue timing for accumulator stores, segment moves,
// control register writes and extending moves.
// Assumes fetch holds its bytes stable while in_valid is high and not taken.
//
// What this block does
// - Accumulator short-form store A2/A3 takes one clock in either mode.
// - Load of segment register via 8E: one clock real, six protected.
// - Store of segment register via 8C takes one clock in either mode.
// - Sign-extending move 0F BE/BF: one clock, arithmetic flags untouched.
// - Zero-extending move 0F B6/B7: one clock, arithmetic flags untouched.
// - Control register writes take 20/5/5/5 real and 18/5/6/6 protected clocks.
`timescale 1ns/10ps
`include "mdx_regs.svh"
module mdx_decode
	import mdx_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fetch side
	input wire logic in_valid,
	input wire mdx_fetch_s in_bytes,
	input wire logic [15:0] src_operand,
	input wire logic prot_mode,
	output logic in_ready,
	// Execution side
	output logic out_valid,
	output mdx_issue_s out_issue
);

	typedef enum logic {
		MDX_IDLE,
		MDX_HOLD
	} mdx_state_e;

	mdx_state_e state;
	mdx_state_e next_state;
	mdx_count_t remain;
	mdx_count_t next_remain;
	logic next_in_ready;
	logic next_out_valid;
	mdx_issue_s next_out_issue;
	mdx_issue_s dec;
	logic [31:0] ext_value;
	logic [1:0] mod_field;
	logic [2:0] reg_field;
	logic take;
	logic seg_ok;
	logic is_acc_store;
	logic is_seg_load;
	logic is_seg_store;
	logic is_escape;
	logic is_sign_ext;
	logic is_zero_ext;
	logic ctrl_known;
	mdx_count_t ctrl_clocks;

	assign mod_field = in_bytes.modrm[`MDX_MOD_HI:`MDX_MOD_LO];
	assign reg_field = in_bytes.modrm[`MDX_REG_HI:`MDX_REG_LO];
	assign take = in_valid & in_ready;

	// Opcode classes; the extending forms only count behind the escape byte
	assign seg_ok = (reg_field <= `MDX_SEG_LAST);
	assign is_acc_store = (in_bytes.op0[7:1] == `MDX_OP_ACC_STORE_HI);
	assign is_seg_load = (in_bytes.op0 == `MDX_OP_SEG_LOAD) && seg_ok;
	assign is_seg_store = (in_bytes.op0 == `MDX_OP_SEG_STORE) && seg_ok;
	assign is_escape = (in_bytes.op0 == `MDX_OP_ESCAPE);
	assign is_sign_ext = (in_bytes.op1[7:1] == `MDX_OP_SIGN_EXT_HI);
	assign is_zero_ext = (in_bytes.op1[7:1] == `MDX_OP_ZERO_EXT_HI);

	mdx_extend u_extend (
		.src(src_operand),
		.wide(in_bytes.op1[0]),
		.sign(in_bytes.op1[3]),
		.result(ext_value)
	);

	// Control register count table; only numbers 0, 2, 3 and 4 exist
	always_comb
	begin
		ctrl_known = 1'b1;
		ctrl_clocks = `MDX_CLK_ONE;
		unique case (reg_field)
			`MDX_CTRL0:
			begin
				// The first register carries the longest count in both modes
				ctrl_clocks = prot_mode ? `MDX_CLK_CTRL0_PROT : `MDX_CLK_CTRL0_REAL;
			end
			`MDX_CTRL2:
			begin
				ctrl_clocks = `MDX_CLK_CTRL2;
			end
			`MDX_CTRL3:
			begin
				ctrl_clocks = prot_mode ? `MDX_CLK_CTRL3_PROT : `MDX_CLK_CTRL3_REAL;
			end
			`MDX_CTRL4:
			begin
				ctrl_clocks = prot_mode ? `MDX_CLK_CTRL4_PROT : `MDX_CLK_CTRL4_REAL;
			end
			default:
			begin
				// Nonexistent control register numbers stay unsupported
				ctrl_known = 1'b0;
			end
		endcase
	end

	// Decode of the bytes presented by fetch
	always_comb
	begin
		dec = '0;
		dec.kind = MDX_UNSUPPORTED;
		dec.clocks = `MDX_CLK_ONE;
		// Unknown encodings pass through as one-clock slots; another unit owns them
		dec.flags_write = 1'b0;
		dec.segment_register_field = reg_field;
		if (is_acc_store)
		begin
			dec.kind = MDX_ACC_STORE;
			dec.wide = in_bytes.op0[0];
			dec.clocks = `MDX_CLK_ONE;
		end
		else if (is_seg_load)
		begin
			dec.kind = MDX_SEG_LOAD;
			dec.wide = 1'b1;
			dec.clocks = prot_mode ? `MDX_CLK_SEG_LOAD_PROT : `MDX_CLK_ONE;
		end
		else if (is_seg_store)
		begin
			dec.kind = MDX_SEG_STORE;
			dec.wide = 1'b1;
			dec.clocks = `MDX_CLK_ONE;
		end
		else if (is_escape)
		begin
			if (in_bytes.op1 == `MDX_OP_CTRL_WRITE && mod_field == `MDX_MOD_REGISTER
				&& ctrl_known)
			begin
				dec.kind = MDX_CTRL_WRITE;
				dec.ctrl_index = reg_field;
				dec.wide = 1'b1;
				dec.clocks = ctrl_clocks;
			end
			else if (is_sign_ext)
			begin
				dec.kind = MDX_SIGN_EXTEND;
				dec.wide = in_bytes.op1[0];
				dec.ext_result = ext_value;
				dec.flags_write = 1'b0;
				dec.clocks = `MDX_CLK_ONE;
			end
			else if (is_zero_ext)
			begin
				dec.kind = MDX_ZERO_EXTEND;
				dec.wide = in_bytes.op1[0];
				dec.ext_result = ext_value;
				dec.flags_write = 1'b0;
				dec.clocks = `MDX_CLK_ONE;
			end
		end
	end

	// Issue timing: the slot occupies exactly dec.clocks cycles
	always_comb
	begin
		next_state = state;
		next_remain = remain;
		next_in_ready = in_ready;
		next_out_valid = 1'b0;
		next_out_issue = out_issue;
		unique case (state)
			MDX_IDLE:
			begin
				if (take)
				begin
					next_out_issue = dec;
					if (dec.clocks == `MDX_CLK_ONE)
					begin
						// Single-clock moves issue back to back without a bubble
						next_out_valid = 1'b1;
					end
					else
					begin
						next_state = MDX_HOLD;
						next_remain = dec.clocks - `MDX_CLK_ONE;
						next_in_ready = 1'b0;
					end
				end
			end
			MDX_HOLD:
			begin
				next_remain = remain - `MDX_CLK_ONE;
				// Ready returns with the pulse, so the next take lands one edge later
				if (remain == `MDX_CLK_ONE)
				begin
					next_state = MDX_IDLE;
					next_out_valid = 1'b1;
					next_in_ready = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state <= MDX_IDLE;
			remain <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_issue <= '0;
		end
		else
		begin
			state <= next_state;
			remain <= next_remain;
			in_ready <= next_in_ready;
			out_valid <= next_out_valid;
			out_issue <= next_out_issue;
		end
	end

endmodule : mdx_decode

// >>> mdx_decode_sva.sv
// Port assertions for the data-move decoder.
// Bound into every mdx_decode instance; one clock domain.
`timescale 1ns/10ps
module mdx_decode_sva
	import mdx_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fetch side
	input wire logic in_valid,
	input wire mdx_fetch_s in_bytes,
	input wire logic prot_mode,
	input wire logic in_ready,
	// Execution side
	input wire logic out_valid,
	input wire mdx_issue_s out_issue
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire tk = in_valid && in_ready;
	wire [7:0] o0 = in_bytes.op0;
	wire [7:0] o1 = in_bytes.op1;
	wire esc = tk && o0 == 8'h0F;
	wire seg = tk && in_bytes.modrm[5:3] < 3'h6;
	sequence done1;
		out_valid && in_ready;
	endsequence
	sequence busy5;
		!in_ready [*5];
	endsequence
	a_acc_one: assert property (tk && o0[7:1] == 7'h51 |=> done1)
		else $error("acc store not one clock");
	a_seg_prot: assert property (seg && o0 == 8'h8E && prot_mode |=> busy5 ##1 done1)
		else $error("seg load protected not six clocks");
	a_seg_real: assert property (seg && o0 == 8'h8E && !prot_mode |=> done1)
		else $error("seg load real not one clock");
	a_seg_store: assert property (seg && o0 == 8'h8C |=> done1)
		else $error("seg store not one clock");
	a_sx_one: assert property (esc && o1[7:1] == 7'h5F |=>
		(done1 and !out_issue.flags_write))
		else $error("sign extend timing or flags");
	a_zx_one: assert property (esc && o1[7:1] == 7'h5B |=>
		(done1 and !out_issue.flags_write))
		else $error("zero extend timing or flags");
	a_ctrl_zero: assert property (esc && o1 == 8'h22 && in_bytes.modrm[7:3] == 5'h18 && !prot_mode |=>
		(out_issue.clocks == 5'h14 && !out_valid) [*8])
		else $error("first control write count real");
	a_ctrl_prot: assert property (esc && o1 == 8'h22 && in_bytes.modrm[7:3] == 5'h18 && prot_mode |=>
		(out_issue.clocks == 5'h12 && !out_valid) [*8])
		else $error("first control write count protected");
	a_sx_fill: assert property (out_valid && out_issue.kind == MDX_SIGN_EXTEND && !out_issue.wide
		|-> out_issue.ext_result[31:8] == {24{out_issue.ext_result[7]}})
		else $error("sign fill wrong");
	a_sx_wide: assert property (out_valid && out_issue.kind == MDX_SIGN_EXTEND && out_issue.wide
		|-> out_issue.ext_result[31:16] == {16{out_issue.ext_result[15]}})
		else $error("sign fill wide wrong");
	a_zx_fill: assert property (out_valid && out_issue.kind == MDX_ZERO_EXTEND
		|-> out_issue.ext_result[31:16] == 16'h0000
		&& (out_issue.wide || out_issue.ext_result[15:8] == 8'h00))
		else $error("zero fill wrong");
endmodule : mdx_decode_sva
bind mdx_decode mdx_decode_sva mdx_decode_sva_i (.clk, .rst_b, .in_valid, .in_bytes,
	.prot_mode, .in_ready, .out_valid, .out_issue);

// >>> mdx_exec_model.sv
// Execution-side model: counts completed slots.
// Watches out_valid of one decoder; always ready, never stalls.
`timescale 1ns/10ps
module mdx_exec_model
	import mdx_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Completion
	input wire logic out_valid,
	output int done_count
);
	always_ff @(posedge clk)
	begin
		done_count <= !rst_b ? 0 : done_count + out_valid;
	end
endmodule : mdx_exec_model

// >>> testbench.sv
// Self-checking bench for the data-move decoder.
// Fetch side driven by hand; the model counts completions.
`timescale 1ns/10ps
module testbench
	import mdx_pkg::*;
;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic in_valid = 1'h0;
	mdx_fetch_s in_bytes = '0;
	logic [15:0] src = 16'h0000;
	logic pm = 1'h0;
	logic in_ready, out_valid;
	mdx_issue_s out_issue;
	int errors = 0, checked = 0, sent = 0, done_count;
	always #20 clk = !clk;
	mdx_decode mdx_decode_i (.clk, .rst_b, .in_valid, .in_bytes, .src_operand(src),
		.prot_mode(pm), .in_ready, .out_valid, .out_issue);
	mdx_exec_model mdx_exec_model_i (.clk, .rst_b, .out_valid, .done_count);
	task report_and_stop;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	task chk(input logic ok);
		checked++;
		if (ok !== 1'h1)
		begin
			errors++;
			$display("unexpected at %0t: wrong issue", $time);
		end
	endtask : chk
	// One idle cycle between slots keeps each take unambiguous
	task go(input logic [23:0] b, input logic [15:0] s, input logic p, input mdx_kind_e k,
		input mdx_count_t n, input logic [31:0] x);
		int c;
		c = 0;
		@(posedge clk);
		in_valid <= 1'h1;
		in_bytes <= b;
		src <= s;
		pm <= p;
		// Hold the request until the decoder has room
		do
			@(posedge clk);
		while (in_ready !== 1'h1);
		in_valid <= 1'h0;
		sent++;
		#1;
		while (out_valid !== 1'h1 && c < 40)
		begin
			@(posedge clk);
			#1 c++;
		end
		chk(c + 1 == n && out_issue.kind === k && out_issue.clocks === n
			&& out_issue.ext_result === x && out_issue.flags_write === 1'h0);
	endtask : go
	task t_mov;
		go(24'hA20000, 16'h1234, 1'h0, MDX_ACC_STORE, 5'h01, 32'h0);
		chk(out_issue.wide === 1'h0);
		go(24'hA30000, 16'h1234, 1'h1, MDX_ACC_STORE, 5'h01, 32'h0);
		chk(out_issue.wide === 1'h1);
		go(24'h8E0018, 16'h0, 1'h0, MDX_SEG_LOAD, 5'h01, 32'h0);
		go(24'h8E0028, 16'h0, 1'h1, MDX_SEG_LOAD, 5'h06, 32'h0);
		chk(out_issue.segment_register_field === 3'h5);
		go(24'h8E0030, 16'h0, 1'h1, MDX_UNSUPPORTED, 5'h01, 32'h0);
		go(24'h8C00E8, 16'h0, 1'h1, MDX_SEG_STORE, 5'h01, 32'h0);
		chk(out_issue.segment_register_field === 3'h5);
		$display("move test done");
	endtask : t_mov
	task t_ext;
		go(24'h0FBEC0, 16'h0080, 1'h0, MDX_SIGN_EXTEND, 5'h01, 32'hFFFFFF80);
		chk(out_issue.wide === 1'h0);
		go(24'h0FBFC0, 16'h8001, 1'h1, MDX_SIGN_EXTEND, 5'h01, 32'hFFFF8001);
		go(24'h0FB6C0, 16'h0180, 1'h1, MDX_ZERO_EXTEND, 5'h01, 32'h00000080);
		go(24'h0FB7C0, 16'h8001, 1'h0, MDX_ZERO_EXTEND, 5'h01, 32'h00008001);
		chk(out_issue.wide === 1'h1);
		$display("extend test done");
	endtask : t_ext
	task t_ctrl;
		mdx_count_t n [8];
		logic [2:0] ix [4];
		n = '{5'h14, 5'h05, 5'h05, 5'h05, 5'h12, 5'h05, 5'h06, 5'h06};
		ix = '{3'h0, 3'h2, 3'h3, 3'h4};
		for (int i = 0; i < 8; i++)
		begin
			go({16'h0F22, 2'h3, ix[i % 4], 3'h1}, 16'h0, i[2], MDX_CTRL_WRITE, n[i], 32'h0);
			chk(out_issue.ctrl_index === ix[i % 4] && out_issue.wide === 1'h1);
		end
		go(24'h0F2200, 16'h0, 1'h0, MDX_UNSUPPORTED, 5'h01, 32'h0);
		go(24'h0F22C8, 16'h0, 1'h1, MDX_UNSUPPORTED, 5'h01, 32'h0);
		$display("control test done");
	endtask : t_ctrl
	// Reset in the middle of a long control write must drop the slot
	task t_reset;
		#1;
		chk(in_ready === 1'h1 && out_valid === 1'h0 && out_issue === '0);
		@(posedge clk);
		in_valid <= 1'h1;
		in_bytes <= 24'h0F22C0;
		pm <= 1'h0;
		@(posedge clk);
		in_valid <= 1'h0;
		repeat (3) @(posedge clk);
		#1;
		chk(in_ready === 1'h0 && out_valid === 1'h0 && out_issue.clocks === 5'h14);
		@(posedge clk);
		rst_b <= 1'h0;
		@(posedge clk);
		rst_b <= 1'h1;
		#1;
		chk(in_ready === 1'h1 && out_valid === 1'h0 && out_issue === '0);
		$display("reset test done");
	endtask : t_reset
	initial
	begin
		#20000;
		errors++;
		report_and_stop();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		t_reset();
		t_mov();
		t_ext();
		t_ctrl();
		repeat (2) @(posedge clk);
		chk(done_count == sent);
		report_and_stop();
	end
endmodule : testbench
